/* File: rtl/dcrs_consts.svh */
/*
 * Constants of the DMA channel request-select block: register offsets,
 * field positions, reset values and request numbers.
 * Assumes it is included by bare name; holds definitions only.
 */
`ifndef DCRS_CONSTS_SVH
`define DCRS_CONSTS_SVH

// ==========================================================================
// Sizes and register offsets
// ==========================================================================
`define DCRS_NCH 4
`define DCRS_NSRC 18
`define DCRS_OFF_CON 5'h00
`define DCRS_OFF_REQ 5'h04
`define DCRS_OFF_STA 5'h08
`define DCRS_OFF_STB 5'h0c
`define DCRS_OFF_PAD 5'h10
`define DCRS_OFF_CNT 5'h14
`define DCRS_OFF_WCOL 8'h80
`define DCRS_OFF_RCOL 8'h84
`define DCRS_OFF_PPS 8'h88
`define DCRS_OFF_LCA 8'h8c
`define DCRS_OFF_LRA 8'h90
`define DCRS_OFF_IST 8'h94
`define DCRS_OFF_ICLR 8'h98
`define DCRS_OFF_IEN 8'h9c

// ==========================================================================
// Fields and reset values
// ==========================================================================
`define DCRS_REQ_FORCE 15
`define DCRS_CON_EN 15
`define DCRS_CON_PP 0
`define DCRS_REQ_RST 16'h0000
`define DCRS_CON_RST 16'h0000
`define DCRS_HAS_CAN 1'b1

// ==========================================================================
// Request numbers and the event line that timer 2 selects
// ==========================================================================
`define DCRS_RQ_INT0 8'h00
`define DCRS_RQ_IC1 8'h01
`define DCRS_RQ_OC1 8'h02
`define DCRS_RQ_OC2 8'h06
`define DCRS_RQ_TMR2 8'h07
`define DCRS_RQ_TMR3 8'h08
`define DCRS_RQ_SPI1 8'h0a
`define DCRS_RQ_SER1RX 8'h0b
`define DCRS_RQ_SER1TX 8'h0c
`define DCRS_RQ_ADC1 8'h0d
`define DCRS_RQ_OC3 8'h19
`define DCRS_RQ_OC4 8'h1a
`define DCRS_RQ_TMR4 8'h1b
`define DCRS_RQ_SER2RX 8'h1e
`define DCRS_RQ_CANRX 8'h22
`define DCRS_RQ_IC3 8'h25
`define DCRS_RQ_IC4 8'h26
`define DCRS_RQ_CANTX 8'h46
`define DCRS_SRC_TMR2 5'h04
`endif

/* File: rtl/dcrs_pkg.sv */
/*
 * Types shared by the request-select block.
 * Assumes dcrs_consts.svh is on the include path.
 */
`include "dcrs_consts.svh"
package dcrs_pkg;
	// ======================================================================
	// Types
	// ======================================================================
	typedef logic [7:0] dcrs_addr_t;
	typedef logic [31:0] dcrs_word_t;
	typedef logic [7:0] dcrs_reqnum_t;
	typedef logic [`DCRS_NSRC-1:0] dcrs_evt_t;
	typedef logic [13:0] dcrs_cnt_t;
	// One-hot channel transfer state.
	typedef enum logic [2:0] {
		DCRS_IDLE = 3'b001,
		DCRS_PEND = 3'b010,
		DCRS_WAIT = 3'b100
	} dcrs_state_t;
endpackage

/* File: rtl/dcrs_trig_if.sv */
/*
 * Interface carrying request numbers, peripheral events and the decoded
 * per-channel trigger hits between the top and the request decoder.
 * Assumes a single clock domain; it is purely combinational.
 */
`timescale 1ns/1ps
interface dcrs_trig_if;
	dcrs_pkg::dcrs_reqnum_t sel [`DCRS_NCH]; // Request number of each channel.
	dcrs_pkg::dcrs_evt_t evt; // Peripheral event lines.
	logic [`DCRS_NCH-1:0] hit; // Selected event present, per channel.
	modport mux (input sel, input evt, output hit);
	modport ctl (output sel, output evt, input hit);
endinterface

/* File: rtl/dcrs_req_mux.sv */
/*
 * Request decoder: maps each channel's request number onto one of the
 * peripheral event lines. Unlisted numbers select nothing.
 * Assumes event lines are synchronous single-cycle pulses.
 */
`timescale 1ns/1ps
module dcrs_req_mux (
	dcrs_trig_if.mux tif
);
	import dcrs_pkg::*;

	// ======================================================================
	// Decode
	// ======================================================================
	// Returns {valid, line index} for a request number.
	function automatic logic [5:0] src_of(input dcrs_reqnum_t code);
		case (code)
			`DCRS_RQ_INT0: src_of = 6'h20;
			`DCRS_RQ_IC1: src_of = 6'h21;
			`DCRS_RQ_OC1: src_of = 6'h22;
			`DCRS_RQ_OC2: src_of = 6'h23;
			`DCRS_RQ_TMR2: src_of = 6'h24;
			`DCRS_RQ_TMR3: src_of = 6'h25;
			`DCRS_RQ_SPI1: src_of = 6'h26;
			`DCRS_RQ_SER1RX: src_of = 6'h27;
			`DCRS_RQ_SER1TX: src_of = 6'h28;
			`DCRS_RQ_ADC1: src_of = 6'h29;
			`DCRS_RQ_OC3: src_of = 6'h2a;
			`DCRS_RQ_OC4: src_of = 6'h2b;
			`DCRS_RQ_TMR4: src_of = 6'h2c;
			`DCRS_RQ_SER2RX: src_of = 6'h2d;
			`DCRS_RQ_IC3: src_of = 6'h2e;
			`DCRS_RQ_IC4: src_of = 6'h2f;
			`DCRS_RQ_CANRX: src_of = {`DCRS_HAS_CAN, 5'h10};
			`DCRS_RQ_CANTX: src_of = {`DCRS_HAS_CAN, 5'h11};
			default: src_of = 6'h00;
		endcase
	endfunction

	// Widened event vector so every 5-bit index is in range.
	always_comb begin
		logic [31:0] ev32;
		logic [5:0] s;
		ev32 = {14'h0000, tif.evt};
		s = 6'h00;
		for (int c = 0; c < `DCRS_NCH; c++) begin
			s = src_of(tif.sel[c]);
			tif.hit[c] = s[5] & ev32[s[4:0]];
		end
	end
endmodule

/* File: rtl/dcrs_xfer_ctl.sv */
/*
 * One channel's transfer sequencer: waits for a start, asks for the RAM
 * port, counts elements and reports element and block completion.
 * Assumes grant and ack come from the top's single-port arbiter.
 */
`timescale 1ns/1ps
module dcrs_xfer_ctl (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic en,
	input wire logic start,
	input wire logic grant,
	input wire logic ack,
	input wire dcrs_pkg::dcrs_cnt_t cnt,
	output logic pend,
	output logic busy,
	output dcrs_pkg::dcrs_cnt_t idx,
	output logic elem_done,
	output logic blk_done,
	output logic collide
);
	import dcrs_pkg::*;

	dcrs_state_t st_r, st_nxt; // Sequencer state.
	dcrs_cnt_t idx_r, idx_nxt; // Element index within the block.

	// ======================================================================
	// Next state
	// ======================================================================
	// A start while a transfer is still outstanding is a request collision;
	// it is reported and dropped rather than queued.
	always_comb begin
		st_nxt = st_r;
		idx_nxt = idx_r;
		elem_done = 1'b0;
		blk_done = 1'b0;
		collide = 1'b0;
		if (!en) begin
			st_nxt = DCRS_IDLE;
			idx_nxt = 14'h0000;
		end else begin
			case (st_r)
				DCRS_IDLE: begin
					if (start) st_nxt = DCRS_PEND;
				end
				DCRS_PEND: begin
					collide = start;
					if (grant) st_nxt = DCRS_WAIT;
				end
				DCRS_WAIT: begin
					collide = start;
					if (ack) begin
						elem_done = 1'b1;
						st_nxt = DCRS_IDLE;
						if (idx_r == cnt) begin
							blk_done = 1'b1;
							idx_nxt = 14'h0000;
						end else begin
							idx_nxt = idx_r + 14'h0001;
						end
					end
				end
				default: st_nxt = DCRS_IDLE;
			endcase
		end
	end

	// Registers only.
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			st_r <= DCRS_IDLE;
			idx_r <= 14'h0000;
		end else begin
			st_r <= st_nxt;
			idx_r <= idx_nxt;
		end
	end

	assign pend = (st_r == DCRS_PEND);
	assign busy = (st_r != DCRS_IDLE);
	assign idx = idx_r;
endmodule

/* File: rtl/dcrs_top.sv */
/*
 * Four-channel DMA request selection and trigger block with its register
 * file, RAM request port, shared status and a level interrupt.
 * Assumes one clock mclk (200 MHz), async active-low resetn, a register
 * master that never waits, and peripheral events synchronous to mclk.
 */
// Added by the designer: the register addresses and the plain strobed port.
`timescale 1ns/1ps

// Notes on behaviour
// - Four independent channels, numbered 0 to 3.
// - Count 14 bits; control, select, peripheral 16.
// - Primary and secondary RAM start, 32 bits each.
// - Shared collision, last address, last channel status.
// - Completion flag only pulsed to interrupt controller.
// - Without force, only the selected request starts.
// - Force settable only; writing zero leaves it.
// - Force cleared on completion or channel disable.
// - Low byte picks source; zero is interrupt 0.
// - Codes 07, 08, 1b select timers 2-4.
// - Codes 0b, 0c, 1e select serial ports.
// - Code 0a SPI done, 0d ADC done.
// - Codes 02, 06, 19, 1a select output compares.
// - Codes 01, 25, 26 select input captures.
// - Codes 22, 46 select CAN events.
module dcrs_top (
	input wire logic mclk,
	input wire logic resetn,
	input wire dcrs_pkg::dcrs_addr_t reg_addr,
	input wire dcrs_pkg::dcrs_word_t reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output dcrs_pkg::dcrs_word_t reg_rdata,
	input wire dcrs_pkg::dcrs_evt_t periph_evt,
	input wire logic ram_ack,
	output logic ram_req,
	output dcrs_pkg::dcrs_word_t ram_addr,
	output logic [15:0] ram_periph_addr,
	output logic [1:0] ram_chan,
	output logic [3:0] channel_irq_flag,
	output logic irq
);
	import dcrs_pkg::*;

	// ======================================================================
	// Declarations
	// ======================================================================
	logic [15:0] con_r [4], con_nxt [4]; // Channel control.
	logic [15:0] req_r [4], req_nxt [4]; // Request select, force on top.
	logic [31:0] sta_r [4], sta_nxt [4]; // Primary RAM start.
	logic [31:0] stb_r [4], stb_nxt [4]; // Secondary RAM start.
	logic [15:0] pad_r [4], pad_nxt [4]; // Peripheral address.
	dcrs_cnt_t cnt_r [4], cnt_nxt [4]; // Transfer count, N means N+1.
	logic [3:0] pps_r, pps_nxt; // Ping-pong buffer in use.
	logic [3:0] wcol_r, wcol_nxt; // Write collision flags.
	logic [3:0] rcol_r, rcol_nxt; // Request collision flags.
	logic [3:0] forced_r, forced_nxt; // Outstanding transfer was forced.
	logic [7:0] ist_r, ist_nxt; // Sticky interrupt status.
	logic [7:0] ien_r, ien_nxt; // Interrupt enables.
	logic irq_r, irq_nxt; // Interrupt output.
	logic [3:0] chflag_r, chflag_nxt; // Completion pulses.
	logic [1:0] lca_r, lca_nxt; // Last channel.
	logic [31:0] lra_r, lra_nxt; // Last RAM address.
	logic ram_req_r, ram_req_nxt; // RAM request pending.
	logic [31:0] ram_addr_r, ram_addr_nxt; // RAM address of the request.
	logic [15:0] ram_pad_r, ram_pad_nxt; // Peripheral address of it.
	logic [1:0] ram_ch_r, ram_ch_nxt; // Requesting channel.
	logic [31:0] rdata_r, rdata_nxt; // Read data, valid one cycle.
	logic [3:0] en, pend, busy, start, gnt, ack; // Per-channel handshakes.
	logic [3:0] elem_done, blk_done, collide; // Per-channel events.
	dcrs_cnt_t idx [4]; // Element index of each channel.

	dcrs_trig_if tif ();

	// ======================================================================
	// Helpers
	// ======================================================================
	// True when the access targets the given per-channel register.
	function automatic logic hits_ch(input dcrs_addr_t a, input logic [1:0] c,
		input logic [4:0] off);
		hits_ch = ~a[7] & (a[6:5] == c) & (a[4:0] == off);
	endfunction

	// Lowest set bit as a one-hot vector; lower channels win the port.
	function automatic logic [3:0] first_one(input logic [3:0] v);
		first_one = v & (~v + 4'h1);
	endfunction

	// ======================================================================
	// Channels and request decoder
	// ======================================================================
	dcrs_req_mux u_mux (
		.tif(tif.mux)
	);
	assign tif.evt = periph_evt;

	for (genvar c = 0; c < `DCRS_NCH; c++) begin : g_ch
		assign en[c] = con_r[c][`DCRS_CON_EN];
		assign tif.sel[c] = req_r[c][7:0];
		// Force starts a transfer from idle; otherwise only the chosen event.
		assign start[c] = en[c] & (tif.hit[c] | (req_r[c][`DCRS_REQ_FORCE] & ~busy[c]));
		assign ack[c] = ram_req_r & ram_ack & (ram_ch_r == 2'(c));
		dcrs_xfer_ctl u_xfer (
			.mclk(mclk),
			.resetn(resetn),
			.en(en[c]),
			.start(start[c]),
			.grant(gnt[c]),
			.ack(ack[c]),
			.cnt(cnt_r[c]),
			.pend(pend[c]),
			.busy(busy[c]),
			.idx(idx[c]),
			.elem_done(elem_done[c]),
			.blk_done(blk_done[c]),
			.collide(collide[c])
		);
	end

	// ======================================================================
	// Software registers, status and interrupt
	// ======================================================================
	// Address-type registers are refused while their channel is busy, since
	// changing them mid-transfer would tear the address; the refusal is
	// recorded as a write collision. Hardware sets win over software clears.
	always_comb begin
		logic wr_ch;
		logic fset;
		logic fclr;
		logic [3:0] wset;
		wr_ch = 1'b0;
		fset = 1'b0;
		fclr = 1'b0;
		wset = 4'h0;
		pps_nxt = pps_r;
		forced_nxt = forced_r;
		for (int c = 0; c < `DCRS_NCH; c++) begin
			con_nxt[c] = con_r[c];
			req_nxt[c] = req_r[c];
			sta_nxt[c] = sta_r[c];
			stb_nxt[c] = stb_r[c];
			pad_nxt[c] = pad_r[c];
			cnt_nxt[c] = cnt_r[c];
			wr_ch = reg_wr & ~reg_addr[7] & (reg_addr[6:5] == 2'(c));
			if (hits_ch(reg_addr, 2'(c), `DCRS_OFF_CON) && reg_wr) begin
				con_nxt[c] = reg_wdata[15:0];
			end
			if (hits_ch(reg_addr, 2'(c), `DCRS_OFF_REQ) && reg_wr) begin
				req_nxt[c][7:0] = reg_wdata[7:0];
			end
			if (wr_ch && (reg_addr[4:0] == `DCRS_OFF_STA || reg_addr[4:0] == `DCRS_OFF_STB
				|| reg_addr[4:0] == `DCRS_OFF_PAD || reg_addr[4:0] == `DCRS_OFF_CNT)) begin
				if (busy[c]) begin
					wset[c] = 1'b1;
				end else begin
					if (reg_addr[4:0] == `DCRS_OFF_STA) sta_nxt[c] = reg_wdata;
					if (reg_addr[4:0] == `DCRS_OFF_STB) stb_nxt[c] = reg_wdata;
					if (reg_addr[4:0] == `DCRS_OFF_PAD) pad_nxt[c] = reg_wdata[15:0];
					if (reg_addr[4:0] == `DCRS_OFF_CNT) cnt_nxt[c] = reg_wdata[13:0];
				end
			end
			// Force: software may only set it; a written zero has no effect.
			fset = hits_ch(reg_addr, 2'(c), `DCRS_OFF_REQ) & reg_wr
				& reg_wdata[`DCRS_REQ_FORCE];
			fclr = (elem_done[c] & forced_r[c]) | ~con_nxt[c][`DCRS_CON_EN];
			req_nxt[c][`DCRS_REQ_FORCE] = fset | (req_r[c][`DCRS_REQ_FORCE] & ~fclr);
			req_nxt[c][14:8] = 7'h00;
			// Remember that the current transfer came from the force bit.
			if (elem_done[c] || !en[c]) forced_nxt[c] = 1'b0;
			if (start[c] && !busy[c] && req_r[c][`DCRS_REQ_FORCE]) forced_nxt[c] = 1'b1;
			// Ping-pong mode swaps buffers at the end of every block.
			if (!en[c]) begin
				pps_nxt[c] = 1'b0;
			end else if (blk_done[c] && con_r[c][`DCRS_CON_PP]) begin
				pps_nxt[c] = ~pps_r[c];
			end
		end
		wcol_nxt = wcol_r | wset;
		rcol_nxt = rcol_r | collide;
		if (reg_wr && reg_addr == `DCRS_OFF_WCOL) begin
			wcol_nxt = (wcol_r & ~reg_wdata[3:0]) | wset;
		end
		if (reg_wr && reg_addr == `DCRS_OFF_RCOL) begin
			rcol_nxt = (rcol_r & ~reg_wdata[3:0]) | collide;
		end
		ist_nxt = ist_r | {collide, blk_done};
		if (reg_wr && reg_addr == `DCRS_OFF_ICLR) begin
			ist_nxt = (ist_r & ~reg_wdata[7:0]) | {collide, blk_done};
		end
		ien_nxt = ien_r;
		if (reg_wr && reg_addr == `DCRS_OFF_IEN) ien_nxt = reg_wdata[7:0];
		irq_nxt = |(ist_nxt & ien_nxt);
		chflag_nxt = blk_done;
	end

	// Registers only.
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			for (int c = 0; c < `DCRS_NCH; c++) begin
				con_r[c] <= `DCRS_CON_RST;
				req_r[c] <= `DCRS_REQ_RST;
				sta_r[c] <= 32'h0000_0000;
				stb_r[c] <= 32'h0000_0000;
				pad_r[c] <= 16'h0000;
				cnt_r[c] <= 14'h0000;
			end
			pps_r <= 4'h0;
			wcol_r <= 4'h0;
			rcol_r <= 4'h0;
			forced_r <= 4'h0;
			ist_r <= 8'h00;
			ien_r <= 8'h00;
			irq_r <= 1'b0;
			chflag_r <= 4'h0;
		end else begin
			con_r <= con_nxt;
			req_r <= req_nxt;
			sta_r <= sta_nxt;
			stb_r <= stb_nxt;
			pad_r <= pad_nxt;
			cnt_r <= cnt_nxt;
			pps_r <= pps_nxt;
			wcol_r <= wcol_nxt;
			rcol_r <= rcol_nxt;
			forced_r <= forced_nxt;
			ist_r <= ist_nxt;
			ien_r <= ien_nxt;
			irq_r <= irq_nxt;
			chflag_r <= chflag_nxt;
		end
	end

	// ======================================================================
	// RAM port arbiter
	// ======================================================================
	// One request at a time; the port is only re-granted after the ack, which
	// costs one idle cycle between elements but keeps the address stable.
	always_comb begin
		gnt = 4'h0;
		ram_req_nxt = ram_req_r;
		ram_addr_nxt = ram_addr_r;
		ram_pad_nxt = ram_pad_r;
		ram_ch_nxt = ram_ch_r;
		lra_nxt = lra_r;
		lca_nxt = lca_r;
		if (ram_req_r) begin
			if (ram_ack) begin
				ram_req_nxt = 1'b0;
				lra_nxt = ram_addr_r;
				lca_nxt = ram_ch_r;
			end
		end else if (|pend) begin
			gnt = first_one(pend);
			ram_req_nxt = 1'b1;
			for (int c = 0; c < `DCRS_NCH; c++) begin
				if (gnt[c]) begin
					ram_ch_nxt = 2'(c);
					ram_pad_nxt = pad_r[c];
					ram_addr_nxt = (pps_r[c] ? stb_r[c] : sta_r[c]) + {17'h00000, idx[c], 1'b0};
				end
			end
		end
	end

	// Registers only.
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			ram_req_r <= 1'b0;
			ram_addr_r <= 32'h0000_0000;
			ram_pad_r <= 16'h0000;
			ram_ch_r <= 2'h0;
			lra_r <= 32'h0000_0000;
			lca_r <= 2'h0;
		end else begin
			ram_req_r <= ram_req_nxt;
			ram_addr_r <= ram_addr_nxt;
			ram_pad_r <= ram_pad_nxt;
			ram_ch_r <= ram_ch_nxt;
			lra_r <= lra_nxt;
			lca_r <= lca_nxt;
		end
	end

	// ======================================================================
	// Read data
	// ======================================================================
	// Unmapped addresses and write-only registers read as zero.
	always_comb begin
		logic [1:0] c;
		c = reg_addr[6:5];
		rdata_nxt = 32'h0000_0000;
		if (reg_rd && !reg_addr[7]) begin
			case (reg_addr[4:0])
				`DCRS_OFF_CON: rdata_nxt = {16'h0000, con_r[c]};
				`DCRS_OFF_REQ: rdata_nxt = {16'h0000, req_r[c][15], 7'h00, req_r[c][7:0]};
				`DCRS_OFF_STA: rdata_nxt = sta_r[c];
				`DCRS_OFF_STB: rdata_nxt = stb_r[c];
				`DCRS_OFF_PAD: rdata_nxt = {16'h0000, pad_r[c]};
				`DCRS_OFF_CNT: rdata_nxt = {18'h00000, cnt_r[c]};
				default: rdata_nxt = 32'h0000_0000;
			endcase
		end else if (reg_rd) begin
			case (reg_addr)
				`DCRS_OFF_WCOL: rdata_nxt = {28'h0000000, wcol_r};
				`DCRS_OFF_RCOL: rdata_nxt = {28'h0000000, rcol_r};
				`DCRS_OFF_PPS: rdata_nxt = {28'h0000000, pps_r};
				`DCRS_OFF_LCA: rdata_nxt = {30'h00000000, lca_r};
				`DCRS_OFF_LRA: rdata_nxt = lra_r;
				`DCRS_OFF_IST: rdata_nxt = {24'h000000, ist_r};
				`DCRS_OFF_IEN: rdata_nxt = {24'h000000, ien_r};
				default: rdata_nxt = 32'h0000_0000;
			endcase
		end
	end

	// Registers only.
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) rdata_r <= 32'h0000_0000;
		else rdata_r <= rdata_nxt;
	end

	assign reg_rdata = rdata_r;
	assign ram_req = ram_req_r;
	assign ram_addr = ram_addr_r;
	assign ram_periph_addr = ram_pad_r;
	assign ram_chan = ram_ch_r;
	assign channel_irq_flag = chflag_r;
	assign irq = irq_r;

	// ======================================================================
	// Checks
	// ======================================================================
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);

	chk_force_set: assert property (
		reg_wr && hits_ch(reg_addr, 2'h2, `DCRS_OFF_REQ) && reg_wdata[15]
		|=> req_r[2][15]) else $error("force write did not set the bit");
	chk_force_fall: assert property (
		$fell(req_r[2][15]) |-> $past(elem_done[2] & forced_r[2]) || !en[2])
		else $error("force bit fell without completion or disable");
	chk_start_cause: assert property (
		$rose(pend[2]) |-> $past(tif.hit[2] || req_r[2][15]))
		else $error("channel started without its request or force");
	chk_timer2_map: assert property (
		en[2] && !busy[2] && req_r[2][15:0] == {8'h00, `DCRS_RQ_TMR2}
		&& periph_evt[`DCRS_SRC_TMR2] |=> pend[2]) else $error("timer 2 request missed");
	chk_force_one: assert property (
		forced_r[2] && elem_done[2] && en[2] && !reg_wr |=> !req_r[2][15]
		##1 (!pend[2] || $past(tif.hit[2]))) else $error("forced transfer repeated");
	chk_req_upper: assert property (
		reg_rd && hits_ch(reg_addr, 2'h1, `DCRS_OFF_REQ) |=> rdata_r[14:8] == 7'h00)
		else $error("unimplemented select bits read nonzero");
	chk_cnt_width: assert property (
		reg_rd && hits_ch(reg_addr, 2'h2, `DCRS_OFF_CNT) |=> rdata_r[31:14] == 18'h00000)
		else $error("count register wider than 14 bits");
	chk_sta_write: assert property (
		reg_wr && hits_ch(reg_addr, 2'h2, `DCRS_OFF_STA) && !busy[2]
		|=> sta_r[2] == $past(reg_wdata)) else $error("primary start not stored");
	chk_irq_pulse: assert property (
		blk_done[2] |=> channel_irq_flag[2] ##1 !channel_irq_flag[2] || $past(blk_done[2]))
		else $error("completion flag not pulsed");
	chk_last_chan: assert property (
		ram_req_r && ram_ack |=> lca_r == $past(ram_ch_r) && lra_r == $past(ram_addr_r))
		else $error("last access status not updated");
endmodule

/* File: verif/dcrs_periph_model.sv */
/*
 * Partner model: peripherals that raise request pulses, and a RAM port that
 * accepts requests at once or stalls while hold is high.
 * Assumes one clock mclk and the asynchronous active-low resetn.
 */
`timescale 1ns/1ps
module dcrs_periph_model (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic fire,
	input wire logic [4:0] src,
	input wire logic hold,
	input wire logic ram_req,
	output logic ram_ack,
	output dcrs_pkg::dcrs_evt_t periph_evt
);
	import dcrs_pkg::*;
	// ======================================================================
	// Events and RAM acknowledge
	// ======================================================================
	// Events are single-cycle pulses; ack is one cycle and only while a request stands.
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			periph_evt <= '0;
			ram_ack <= 1'b0;
		end else begin
			periph_evt <= fire ? (dcrs_evt_t'(1) << src) : '0;
			ram_ack <= ram_req && !ram_ack && !hold;
		end
	end
endmodule

/* File: verif/dcrs_top_bench.sv */
/*
 * Bench for the request-select block: register tasks, trigger table,
 * forced transfers and the interrupt.
 * Assumes the partner model file is compiled before this one.
 */
`timescale 1ns/1ps
module dcrs_top_bench;
	import dcrs_pkg::*;
	logic mclk, resetn, reg_wr, reg_rd, fire, hold, ram_req, ram_ack, irq, seen;
	dcrs_addr_t reg_addr;
	dcrs_word_t reg_wdata, reg_rdata, ram_addr;
	dcrs_evt_t periph_evt;
	logic [15:0] ram_periph_addr;
	logic [1:0] ram_chan;
	logic [3:0] channel_irq_flag;
	logic [4:0] src;
	int n_errors, samples_checked, cyc, nflag;
	// Request codes in the order of the event lines.
	logic [7:0] codes [18] = '{8'h00, 8'h01, 8'h02, 8'h06, 8'h07, 8'h08, 8'h0a, 8'h0b,
		8'h0c, 8'h0d, 8'h19, 8'h1a, 8'h1b, 8'h1e, 8'h25, 8'h26, 8'h22, 8'h46};
	dcrs_top DUT (.mclk(mclk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .periph_evt(periph_evt),
		.ram_ack(ram_ack), .ram_req(ram_req), .ram_addr(ram_addr),
		.ram_periph_addr(ram_periph_addr), .ram_chan(ram_chan),
		.channel_irq_flag(channel_irq_flag), .irq(irq));
	dcrs_periph_model peer (.mclk(mclk), .resetn(resetn), .fire(fire), .src(src),
		.hold(hold), .ram_req(ram_req), .ram_ack(ram_ack), .periph_evt(periph_evt));
	// ======================================================================
	// Clock, timeout and flag counting
	// ======================================================================
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	// Flag pulses are counted here since each stands for one cycle only.
	always @(posedge mclk) begin
		cyc++;
		if (channel_irq_flag[2] === 1'b1) nflag++;
		if (cyc == 20000) begin
			n_errors++;
			test_done();
		end
	end
	// ======================================================================
	// Tasks
	// ======================================================================
	task chk(input dcrs_word_t got, input dcrs_word_t exp);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task wr(input dcrs_addr_t a, input dcrs_word_t d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe, so sample there.
	task rd(input dcrs_addr_t a, input dcrs_word_t exp);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, exp);
	endtask
	task wt(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	// Bounded watch for a RAM request.
	task wreq(input int n);
		seen = 1'b0;
		repeat (n) begin
			wt(1);
			if (ram_req === 1'b1) seen = 1'b1;
		end
	endtask
	task pulse(input int i);
		@(posedge mclk);
		fire <= 1'b1;
		src <= 5'(i);
		@(posedge mclk);
		fire <= 1'b0;
	endtask
	task test_done;
		$display("errors %0d checks %0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// ======================================================================
	// Main sequence
	// ======================================================================
	initial begin
		resetn = 1'b0;
		{reg_wr, reg_rd, fire, hold, src, reg_addr, reg_wdata} = '0;
		repeat (12) @(posedge mclk);
		resetn <= 1'b1;
		for (int c = 0; c < 4; c++) begin
			rd(8'(c * 32 + 4), 32'h0);
			rd(8'(c * 32), 32'h0);
		end
		wr(8'h44, 32'hffff7fff);
		rd(8'h44, 32'h000000ff);
		wr(8'h54, 32'hffffffff);
		rd(8'h54, 32'h00003fff);
		wr(8'h54, 32'h0);
		wr(8'h48, 32'h00001000);
		rd(8'h48, 32'h00001000);
		wr(8'h4c, 32'h00002000);
		wr(8'h50, 32'h00000abc);
		wr(8'h9c, 32'h4);
		// Ping-pong on: odd blocks use the secondary start address.
		wr(8'h40, 32'h8001);
		// Every code: a foreign event must not start, the selected one must.
		for (int i = 0; i < 18; i++) begin
			wr(8'h44, 32'(codes[i]));
			pulse((i + 1) % 18);
			wreq(8);
			chk(32'(seen), 32'h0);
			hold <= 1'b1;
			pulse(i);
			wreq(8);
			chk(32'(seen), 32'h1);
			chk(ram_addr, (i % 2) ? 32'h00002000 : 32'h00001000);
			chk({ram_periph_addr, 14'h0, ram_chan}, 32'h0abc0002);
			hold <= 1'b0;
			wt(4);
		end
		chk(32'(nflag), 32'd18);
		chk(32'(irq), 32'h1);
		rd(8'h94, 32'h4);
		rd(8'h8c, 32'h2);
		rd(8'h90, 32'h00002000);
		wr(8'h9c, 32'h0);
		wt(2);
		chk(32'(irq), 32'h0);
		wr(8'h9c, 32'h4);
		wt(2);
		chk(32'(irq), 32'h1);
		wr(8'h98, 32'h4);
		wt(2);
		chk(32'(irq), 32'h0);
		// Forced transfer with an unlisted code, cleared only by hardware.
		hold <= 1'b1;
		wr(8'h44, 32'h8055);
		wreq(8);
		chk(32'(seen), 32'h1);
		wr(8'h44, 32'h0);
		rd(8'h44, 32'h8000);
		hold <= 1'b0;
		wt(6);
		rd(8'h44, 32'h0);
		rd(8'h88, 32'h4);
		wreq(8);
		chk(32'(seen), 32'h0);
		hold <= 1'b1;
		wr(8'h44, 32'h8000);
		wt(4);
		// Busy channel: start address write refused, selected event collides.
		wr(8'h48, 32'h00003000);
		rd(8'h80, 32'h4);
		rd(8'h48, 32'h00001000);
		pulse(0);
		rd(8'h84, 32'h4);
		wr(8'h40, 32'h0);
		rd(8'h44, 32'h0);
		hold <= 1'b0;
		rd(8'h7c, 32'h0);
		test_done();
	end
endmodule
